// ==== design/sbsc_top.sv ====
// Cycle control of a synchronous flow-through burst SRAM.
// Assumes all bus pins except sleep, order select and output enable are synchronous to mclk_i.
// Notes on behaviour
// - Order select high: burst address low bits are start XOR beat count.
// - Order select low: low bits step up by one per beat, wrapping.
// - Sleep input is asynchronous; it floats the bus at once, but takes effect after two clock edges.
// - While asleep, synchronous inputs are ignored and the data bus floats.
// - Sleep entry and exit complete within two clock cycles.
// - Array contents are kept unchanged throughout sleep.
// - An access pending at sleep entry is dropped as invalid.
// - Begin burst only with selects valid and a strobe low; else deselect.
// - Controller-strobe begin with processor strobe high writes if write decoded.
// - No strobe, advance low: step the counter and access the next address.
// - No strobe, advance high: hold the counter and repeat the access.
// - Decoded write is global write low, or byte enable and a lane low.
// - A processor-strobe begin is always a read.
// - Writes only in a burst continuation cycle or on a controller-strobe begin.
// - Output enable is masked internally during writes.
// - In reads, low output enable drives the bus combinationally.
// - Burst counter loads from the lowest two address bits at burst start.
// - Controller strobe is ignored while the processor strobe and the first select are both low.
// - Global write low writes every byte lane, parity included.
`timescale 1ns/1ps
`include "sbsc_consts.svh"
module sbsc_top #(
  parameter int DEPTH = `SBSC_DEPTH,
  parameter int AW    = `SBSC_ADDR_W,
  parameter int WIDTH = `SBSC_DATA_W,
  parameter int LANES = `SBSC_LANES
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  input  wire logic [AW-1:0]    addr_i,
  input  wire logic             chip_sel_first_n_i,
  input  wire logic             chip_sel_second_i,
  input  wire logic             chip_sel_third_n_i,
  input  wire logic             processor_addr_strobe_n_i,
  input  wire logic             controller_addr_strobe_n_i,
  input  wire logic             burst_advance_n_i,
  input  wire logic             global_write_n_i,
  input  wire logic             byte_write_enable_n_i,
  input  wire logic [LANES-1:0] byte_lane_select_n_i,
  input  wire logic             burst_order_i,
  input  wire logic             sleep_request_i,
  input  wire logic             output_enable_n_i,
  input  wire logic [WIDTH-1:0] dq_i,
  output logic [WIDTH-1:0]      dq_o,
  output logic                  dq_oe_o,
  output logic                  asleep_o
);
  localparam int CW        = `SBSC_CNT_W;
  localparam int SLEEP_CYC = `SBSC_SLEEP_CYC;
  localparam int REQ_W     = $bits(sbsc_pkg::sbsc_wr_req_t);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic [CW-1:0] burst_low(input logic [CW-1:0] start,
                                              input logic [CW-1:0] beat,
                                              input logic          interleave);
    burst_low = interleave ? (start ^ beat) : CW'(start + beat);
  endfunction

  function automatic logic write_decode_n(input logic             gw_n,
                                          input logic             bwe_n,
                                          input logic [LANES-1:0] bsel_n);
    write_decode_n = gw_n & (bwe_n | (&bsel_n));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Asynchronous pins: sleep and order select pass two flip-flops.

  logic sleep_meta;
  logic order_meta;
  logic order_sync;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sleep_meta <= 1'b0;
      asleep_o   <= 1'b0;
    end else begin
      sleep_meta <= sleep_request_i;
      asleep_o   <= sleep_meta;
    end
  end

  // Order select defaults to interleaved, as a floating strap pulls high.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      order_meta <= 1'b1;
      order_sync <= 1'b1;
    end else begin
      order_meta <= burst_order_i;
      order_sync <= order_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle decode.

  sbsc_pkg::sbsc_cyc_state_t state;
  logic [AW-1:0]             base;
  logic [CW-1:0]             beat;
  logic [AW-1:0]             next_base;
  logic [CW-1:0]             next_beat;
  logic [AW-1:0]             acc_addr;
  logic                      selected;
  logic                      strobe;
  logic                      begin_burst;
  logic                      proc_begin;
  logic                      ctrl_begin;
  logic                      cont_cyc;
  logic                      write_n;
  logic                      rd_now;
  logic                      wr_now;
  logic                      rd_cycle;
  logic                      fifo_in_ready;
  logic [LANES-1:0]          wr_lanes;

  assign selected = !chip_sel_first_n_i & chip_sel_second_i & !chip_sel_third_n_i;
  // The processor strobe counts only with the first select low; the controller
  // strobe is then irrelevant because either one starts a cycle.
  assign strobe      = (!processor_addr_strobe_n_i & !chip_sel_first_n_i)
                       | !controller_addr_strobe_n_i;
  assign begin_burst = !asleep_o & strobe & selected;
  assign proc_begin  = begin_burst & !processor_addr_strobe_n_i;
  assign ctrl_begin  = begin_burst & processor_addr_strobe_n_i;
  assign cont_cyc    = !asleep_o & !strobe & (state == sbsc_pkg::SBSC_BURST);
  assign write_n     = write_decode_n(global_write_n_i, byte_write_enable_n_i,
                                      byte_lane_select_n_i);
  assign rd_now      = proc_begin | ((ctrl_begin | cont_cyc) & write_n);
  // A write is refused when the write queue cannot take it.
  assign wr_now      = (ctrl_begin | cont_cyc) & !write_n & fifo_in_ready;
  assign wr_lanes    = global_write_n_i ? ~byte_lane_select_n_i : '1;

  always_comb begin
    next_base = base;
    next_beat = beat;
    if (begin_burst) begin
      next_base = addr_i;
      next_beat = `SBSC_CNT_ZERO;
    end else if (cont_cyc && !burst_advance_n_i) begin
      next_beat = beat + `SBSC_CNT_STEP;
    end
  end
  // With advance high next_beat equals beat, so the access repeats.

  assign acc_addr = {next_base[AW-1:CW],
                     burst_low(next_base[CW-1:0], next_beat, order_sync)};

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      base <= '0;
      beat <= `SBSC_CNT_ZERO;
    end else begin
      base <= next_base;
      beat <= next_beat;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= sbsc_pkg::SBSC_IDLE;
    end else begin
      case (state)
        sbsc_pkg::SBSC_IDLE: begin
          if (begin_burst) begin
            state <= sbsc_pkg::SBSC_BURST;
          end
        end
        sbsc_pkg::SBSC_BURST: begin
          if (asleep_o || (strobe && !selected)) begin
            state <= sbsc_pkg::SBSC_IDLE;
          end
        end
        default: begin
          state <= sbsc_pkg::SBSC_IDLE;
        end
      endcase
    end
  end

  // Marks a read in flight; writes clear it so output enable is masked.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_cycle <= 1'b0;
    end else begin
      rd_cycle <= rd_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write queue and array.

  sbsc_pkg::sbsc_wr_req_t wr_req;
  sbsc_pkg::sbsc_wr_req_t wq_head;
  logic                   wq_valid;

  // Data are taken from the bus on the same edge as the write controls.
  // The carrier is sized for the full part; a smaller instance pads here and
  // trims again at the array, so a wider address than the carrier is not supported.
  assign wr_req = '{addr:  `SBSC_ADDR_W'(acc_addr),
                    data:  `SBSC_DATA_W'(dq_i),
                    lanes: `SBSC_LANES'(wr_lanes)};

  // The array stalls draining while asleep and the queue is held flushed for the
  // whole of sleep, so pending writes are dropped at entry and reads stay coherent.
  sbsc_fifo #(
    .WIDTH (REQ_W),
    .DEPTH (`SBSC_FIFO_DEPTH)
  ) u_wq (
    .mclk_i      (mclk_i),
    .rst_b_i     (rst_b_i),
    .flush_i     (asleep_o),
    .in_valid_i  (wr_now),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (wr_req),
    .out_valid_o (wq_valid),
    .out_ready_i (!asleep_o),
    .out_data_o  (wq_head)
  );

  sbsc_mem #(
    .DEPTH (DEPTH),
    .WIDTH (WIDTH),
    .LANES (LANES),
    .AW    (AW)
  ) u_mem (
    .mclk_i   (mclk_i),
    .we_i     (wq_valid & !asleep_o),
    .waddr_i  (AW'(wq_head.addr)),
    .wdata_i  (WIDTH'(wq_head.data)),
    .wlanes_i (LANES'(wq_head.lanes)),
    .re_i     (rd_now),
    .raddr_i  (acc_addr),
    .rdata_o  (dq_o)
  );

  // Output enable and sleep act without the clock; only the read flag is
  // registered, so the drivers follow the pins within gate delay.
  assign dq_oe_o = rd_cycle & !output_enable_n_i & !sleep_request_i;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sleep_bus_float_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i) asleep_o |-> !dq_oe_o && !wr_now && !rd_now)
    else $error("Bus driven or access taken while asleep.");

  sleep_entry_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    $rose(sleep_request_i) ##1 sleep_request_i |-> ##[0:SLEEP_CYC] asleep_o)
    else $error("Sleep entry took more than two cycles.");

  sleep_exit_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    $fell(sleep_request_i) ##1 !sleep_request_i |-> ##[0:SLEEP_CYC] !asleep_o)
    else $error("Sleep exit took more than two cycles.");

  proc_start_read_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i) proc_begin |-> rd_now && !wr_now ##1 rd_cycle)
    else $error("Processor strobe start was not a read.");

  write_origin_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    wr_now |-> (ctrl_begin || (state == sbsc_pkg::SBSC_BURST && !strobe)))
    else $error("Write outside a permitted cycle.");

  deselect_idle_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    (!asleep_o && strobe && !selected) |=> state == sbsc_pkg::SBSC_IDLE && !rd_cycle)
    else $error("Invalid select combination did not deselect.");

  burst_load_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    begin_burst |=> base == $past(addr_i) && beat == `SBSC_CNT_ZERO)
    else $error("Burst counter not loaded from the address.");

  burst_linear_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    (cont_cyc && !burst_advance_n_i && !order_sync)
    |-> acc_addr[CW-1:0] == CW'(base[CW-1:0] + beat + `SBSC_CNT_STEP))
    else $error("Linear burst step wrong.");

  burst_inter_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    (cont_cyc && !burst_advance_n_i && order_sync)
    |-> acc_addr[CW-1:0] == (base[CW-1:0] ^ CW'(beat + `SBSC_CNT_STEP)))
    else $error("Interleaved burst step wrong.");

  burst_hold_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    (cont_cyc && burst_advance_n_i) |=> beat == $past(beat) && base == $past(base))
    else $error("Suspended burst moved the counter.");

  all_lanes_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i) (wr_now && !global_write_n_i) |-> &wr_req.lanes)
    else $error("Global write missed a byte lane.");

  write_oe_mask_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i) wr_now |=> !dq_oe_o)
    else $error("Bus driven during a write.");

  begin_addr_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i) begin_burst |-> acc_addr == addr_i)
    else $error("Burst start did not use the external address.");

  begin_read_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i) (begin_burst && write_n) |=> rd_cycle)
    else $error("Valid burst start without a write did not read.");

  ctrl_write_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ctrl_begin && !write_n && fifo_in_ready) |-> wr_now && !rd_now)
    else $error("Controller strobe write was not taken.");

  global_write_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i) !global_write_n_i |-> !write_n)
    else $error("Global write not decoded as a write.");

  no_write_decode_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    (global_write_n_i && byte_write_enable_n_i) |-> write_n)
    else $error("Write decoded without any write enable.");

  lane_only_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    (wr_now && global_write_n_i) |-> (LANES'(wr_req.lanes) & byte_lane_select_n_i) == '0)
    else $error("Byte write touched an unselected lane.");

  oe_follow_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    (rd_cycle && !sleep_request_i) |-> dq_oe_o == !output_enable_n_i)
    else $error("Output drive did not follow output enable in a read.");

  sleep_pin_float_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i) sleep_request_i |-> !dq_oe_o)
    else $error("Bus driven while the sleep pin is high.");

  sleep_queue_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i) asleep_o |=> !wq_valid)
    else $error("Queued write survived sleep entry.");
endmodule // sbsc_top

// ==== design/sbsc_consts.svh ====
// Constants for the synchronous burst SRAM cycle logic.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SBSC_CONSTS_SVH
`define SBSC_CONSTS_SVH
`define SBSC_ADDR_W            18
`define SBSC_DATA_W            36
`define SBSC_LANES             4
`define SBSC_DEPTH             262144
`define SBSC_FIFO_DEPTH        4
`define SBSC_CNT_W             2
`define SBSC_CNT_ZERO          2'h0
`define SBSC_CNT_STEP          2'h1
`define SBSC_CLK_PERIOD_NS     40
`define SBSC_SLEEP_RECOVERY_NS (2 * `SBSC_CLK_PERIOD_NS)
`define SBSC_SLEEP_CYC \
  ((`SBSC_SLEEP_RECOVERY_NS + `SBSC_CLK_PERIOD_NS - 1) / `SBSC_CLK_PERIOD_NS)
`endif

// ==== design/sbsc_pkg.sv ====
// Types shared by the burst SRAM cycle logic.
// Assumes the constants header is on the include path.
`include "sbsc_consts.svh"
package sbsc_pkg;
  typedef struct packed {
    logic [`SBSC_ADDR_W-1:0] addr;
    logic [`SBSC_DATA_W-1:0] data;
    logic [`SBSC_LANES-1:0]  lanes;
  } sbsc_wr_req_t;

  typedef enum logic {
    SBSC_IDLE,
    SBSC_BURST
  } sbsc_cyc_state_t;
endpackage

// ==== design/sbsc_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides and a flush.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module sbsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic             push;
  logic             pop;

  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_valid_o = (count != '0);
  assign out_data_o  = store[rd_ptr];

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      in_ready_o <= 1'b1;
    end else if (flush_i) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      in_ready_o <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + PW'(1);
      end
      if (push && !pop) begin
        count      <= count + CW'(1);
        in_ready_o <= (count + CW'(1)) != FULL;
      end else if (pop && !push) begin
        count      <= count - CW'(1);
        in_ready_o <= 1'b1;
      end else begin
        in_ready_o <= (count != FULL);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (push) begin
      store[wr_ptr] <= in_data_i;
    end
  end
endmodule // sbsc_fifo

// ==== design/sbsc_mem.sv ====
// Byte-lane writable array with a registered read port.
// A read of the word being written in the same edge returns the merged new data.
`timescale 1ns/1ps
module sbsc_mem #(
  parameter int DEPTH = 1024,
  parameter int WIDTH = 36,
  parameter int LANES = 4,
  parameter int AW    = 10
) (
  input  wire logic             mclk_i,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [LANES-1:0] wlanes_i,
  input  wire logic             re_i,
  input  wire logic [AW-1:0]    raddr_i,
  output logic [WIDTH-1:0]      rdata_o
);
  localparam int LW = WIDTH / LANES;

  logic [WIDTH-1:0] array [DEPTH];
  logic [WIDTH-1:0] merged;

  // Only lanes flagged in the write are replaced; others keep stored bits.
  always_comb begin
    merged = array[waddr_i];
    for (int l = 0; l < LANES; l++) begin
      if (wlanes_i[l]) begin
        merged[l*LW +: LW] = wdata_i[l*LW +: LW];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      array[waddr_i] <= merged;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (re_i) begin
      rdata_o <= (we_i && waddr_i == raddr_i) ? merged : array[raddr_i];
    end
  end
endmodule // sbsc_mem

// ==== testbench/sbsc_master_model.sv ====
// Bus master model that drives the synchronous pins of the burst SRAM cycle logic.
// Assumes the bench calls its tasks; pins change only at the falling clock edge.
`timescale 1ns/1ps
module sbsc_master_model (
  input  wire logic        mclk_i,
  input  wire logic [35:0] dq_i,
  input  wire logic        dq_oe_i,
  output logic [5:0]       addr_o,
  output logic             first_n_o,
  output logic             second_o,
  output logic             third_n_o,
  output logic             ps_n_o,
  output logic             cs_n_o,
  output logic             adv_n_o,
  output logic             gw_n_o,
  output logic             bwe_n_o,
  output logic [3:0]       bsel_n_o,
  output logic             order_o,
  output logic             sleep_o,
  output logic             oe_n_o,
  output logic [35:0]      data_o
);
  initial begin
    {addr_o, second_o, third_n_o, data_o, sleep_o} = '0;
    {first_n_o, ps_n_o, cs_n_o, adv_n_o, gw_n_o, bwe_n_o, order_o, oe_n_o} = '1;
    bsel_n_o = 4'hf;
  end

  // Returns what the bus showed just before the new pins were applied.
  task automatic step(input logic ps, cs, burst_advance_n, gw, byte_write_enable_n, input logic [3:0] bs,
                      input logic [5:0] a, input logic [35:0] d, input logic oe, sel2,
                      output logic [35:0] q, output logic qe);
    logic wr;
    @(negedge mclk_i);
    q = dq_i;
    qe = dq_oe_i;
    wr = !gw || (!byte_write_enable_n && !(&bs));
    first_n_o = ps & cs;
    second_o = sel2;
    {ps_n_o, cs_n_o, adv_n_o, gw_n_o, bwe_n_o, bsel_n_o, addr_o} = {ps, cs, burst_advance_n, gw, byte_write_enable_n, bs, a};
    // A released bus shows the inverse of its last value, never a stale copy.
    data_o = wr ? d : ~data_o;
    oe_n_o = (!cs && ps && wr) ? 1'b1 : oe;
  endtask

  task automatic set_pin(input logic order, sleep);
    @(negedge mclk_i);
    order_o = order;
    sleep_o = sleep;
  endtask

  task automatic set_third(input logic v);
    @(negedge mclk_i);
    third_n_o = v;
  endtask

  task automatic sleep_enter(input logic order);
    logic [35:0] q;
    logic qe;
    step(0, 1, 1, 1, 1, 4'hf, '0, '0, 0, 0, q, qe);
    set_pin(order, 1'b1);
  endtask

  task automatic sleep_exit(input logic order);
    logic [35:0] q;
    logic qe;
    set_pin(order, 1'b0);
    repeat (2) step(1, 1, 1, 1, 1, 4'hf, '0, '0, 0, 1, q, qe);
  endtask
endmodule // sbsc_master_model

// ==== testbench/tb_sync_burst_sram_cycle_logic.sv ====
// Self-checking bench for the burst SRAM cycle logic, with a shadow copy of the array.
// Assumes the master model in its own file and a 64-word array for speed.
`timescale 1ns/1ps
module tb_sync_burst_sram_cycle_logic;
  logic        mclk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [5:0]  addr;
  logic        first_n, second, third_n, ps_n, cs_n, adv_n, gw_n, bwe_n;
  logic [3:0]  bsel_n;
  logic        order, sleep, oe_n, dq_oe_o, asleep_o;
  logic [35:0] dq_in, dq_o;
  logic [35:0] shadow [64];
  int          mismatches = 0;
  int          comparisons = 0;

  initial forever #20 mclk_i = ~mclk_i;

  sbsc_top #(.DEPTH(64), .AW(6)) sbsc_top_inst (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr), .chip_sel_first_n_i(first_n),
    .chip_sel_second_i(second), .chip_sel_third_n_i(third_n),
    .processor_addr_strobe_n_i(ps_n), .controller_addr_strobe_n_i(cs_n),
    .burst_advance_n_i(adv_n), .global_write_n_i(gw_n), .byte_write_enable_n_i(bwe_n),
    .byte_lane_select_n_i(bsel_n), .burst_order_i(order), .sleep_request_i(sleep),
    .output_enable_n_i(oe_n), .dq_i(dq_in), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
    .asleep_o(asleep_o));

  sbsc_master_model sbsc_master_model_inst (
    .mclk_i(mclk_i), .dq_i(dq_o), .dq_oe_i(dq_oe_o), .addr_o(addr), .first_n_o(first_n),
    .second_o(second), .third_n_o(third_n), .ps_n_o(ps_n), .cs_n_o(cs_n), .adv_n_o(adv_n),
    .gw_n_o(gw_n), .bwe_n_o(bwe_n), .bsel_n_o(bsel_n), .order_o(order), .sleep_o(sleep),
    .oe_n_o(oe_n), .data_o(dq_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_word(input logic [35:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [35:0] d, input logic gw, byte_write_enable_n,
                    input logic [3:0] bs);
    logic [35:0] q;
    logic qe;
    sbsc_master_model_inst.step(1, 0, 1, gw, byte_write_enable_n, bs, a, d, 0, 1, q, qe);
    for (int l = 0; l < 4; l++)
      if (!gw || (!byte_write_enable_n && !bs[l])) shadow[a][9*l +: 9] = d[9*l +: 9];
  endtask

  task automatic rd1(input logic [5:0] a, input logic oe);
    logic [35:0] q;
    logic qe;
    sbsc_master_model_inst.step(0, 1, 1, 1, 1, 4'hf, a, '0, oe, 1, q, qe);
    sbsc_master_model_inst.step(1, 1, 1, 1, 1, 4'hf, a, '0, oe, 1, q, qe);
    check_bit(qe, !oe);
    if (!oe) check_word(q, shadow[a]);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_write_read;
    for (int a = 0; a < 16; a++) wr(6'(a), {6{6'(a)}}, 0, 1, 4'hf);
    rd1(6'h05, 1'b0);
    rd1(6'h05, 1'b1);
    $display("test write_read done");
  endtask

  task automatic t_lanes;
    wr(6'h0c, 36'h0_0000_0000, 1, 0, 4'b1110);
    wr(6'h0c, 36'hf_ffff_ffff, 1, 0, 4'b1111);
    wr(6'h0c, 36'hf_ffff_ffff, 1, 1, 4'b0000);
    wr(6'h0d, 36'h0_0000_0000, 1, 0, 4'b0101);
    rd1(6'h0c, 1'b0);
    rd1(6'h0d, 1'b0);
    $display("test lanes done");
  endtask

  task automatic t_bursts;
    logic [35:0] q;
    logic qe;
    logic [1:0] b, lo;
    for (int il = 1; il >= 0; il--) begin
      sbsc_master_model_inst.set_pin(1'(il), 1'b0);
      for (int s = 0; s < 4; s++) begin
        sbsc_master_model_inst.step(0, 1, 1, 1, 1, 4'hf, 6'(s), '0, 0, 1, q, qe);
        b = 2'h0;
        for (int i = 1; i <= 6; i++) begin
          sbsc_master_model_inst.step(1, 1, (i == 2), 1, 1, 4'hf, '0, '0, 0, 1, q, qe);
          lo = il ? 2'(s) ^ b : 2'(s) + b;
          check_word(q, shadow[{4'h0, lo}]);
          check_bit(qe, 1'b1);
          if (i != 2) b = b + 2'h1;
        end
      end
    end
    $display("test bursts done");
  endtask

  task automatic t_proc;
    logic [35:0] q;
    logic qe;
    sbsc_master_model_inst.step(0, 1, 1, 0, 1, 4'hf, 6'h08, 36'h0_0000_0000, 0, 1, q, qe);
    sbsc_master_model_inst.step(1, 1, 0, 0, 1, 4'hf, 6'h08, 36'ha_5a5a_5a5a, 0, 1, q, qe);
    check_word(q, shadow[8]);
    check_bit(qe, 1'b1);
    shadow[9] = 36'ha_5a5a_5a5a;
    sbsc_master_model_inst.step(1, 1, 1, 1, 1, 4'hf, 6'h08, '0, 0, 1, q, qe);
    check_bit(qe, 1'b0);
    rd1(6'h08, 1'b0);
    rd1(6'h09, 1'b0);
    $display("test proc_strobe done");
  endtask

  task automatic t_deselect;
    logic [35:0] q;
    logic qe;
    sbsc_master_model_inst.step(0, 1, 1, 1, 1, 4'hf, 6'h05, '0, 0, 0, q, qe);
    sbsc_master_model_inst.step(1, 1, 0, 1, 1, 4'hf, 6'h05, '0, 0, 1, q, qe);
    check_bit(qe, 1'b0);
    sbsc_master_model_inst.step(1, 1, 1, 1, 1, 4'hf, 6'h05, '0, 0, 1, q, qe);
    check_bit(qe, 1'b0);
    sbsc_master_model_inst.set_third(1'b1);
    sbsc_master_model_inst.step(1, 0, 1, 1, 1, 4'hf, 6'h05, '0, 0, 1, q, qe);
    sbsc_master_model_inst.step(1, 1, 0, 1, 1, 4'hf, 6'h05, '0, 0, 1, q, qe);
    check_bit(qe, 1'b0);
    sbsc_master_model_inst.set_third(1'b0);
    $display("test deselect done");
  endtask

  task automatic t_sleep;
    logic [35:0] q;
    logic qe;
    sbsc_master_model_inst.sleep_enter(1'b0);
    #1 check_bit(dq_oe_o, 1'b0);
    repeat (2) @(negedge mclk_i);
    check_bit(asleep_o, 1'b1);
    wr(6'h05, 36'h0_0000_0000, 0, 1, 4'hf);
    shadow[5] = {6{6'h05}};
    sbsc_master_model_inst.step(0, 1, 1, 1, 1, 4'hf, 6'h05, '0, 0, 1, q, qe);
    sbsc_master_model_inst.step(1, 1, 1, 1, 1, 4'hf, 6'h05, '0, 0, 1, q, qe);
    check_bit(qe, 1'b0);
    sbsc_master_model_inst.sleep_exit(1'b0);
    check_bit(asleep_o, 1'b0);
    rd1(6'h05, 1'b0);
    $display("test sleep done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_b_i = 1'b1;
    t_write_read;
    t_lanes;
    t_bursts;
    t_proc;
    t_deselect;
    t_sleep;
    report_and_stop;
  end

  // The tests need well under a thousand cycles; this bound only catches a hang.
  initial begin
    repeat (20000) @(posedge mclk_i);
    mismatches++;
    report_and_stop;
  end
endmodule // tb_sync_burst_sram_cycle_logic
